// ==== bench/sample_sink.sv ====
// sample sink standing in for the host side of the sample stream
`timescale 1ns/1ns
`default_nettype none
module sample_sink (
  // stream from the block
  input  wire logic        clk,
  input  wire logic        valid,
  input  wire logic [63:0] data,
  output logic             ready,
  // bench control and status
  input  wire logic        stall,
  input  wire logic        settled,
  output var int           words,
  output var int           good_words,
  output logic [63:0]      last_word
);
  initial begin
    words = 0;
    good_words = 0;
    last_word = 64'h0;
    ready = 1'b0;
  end
  always @(posedge clk) begin
    if (valid === 1'b1 && ready === 1'b1) begin
      words <= words + 1;
      last_word <= data;
      // early samples still arrive; only settled ones count in good_words
      if (settled === 1'b1) begin
        good_words <= good_words + 1;
      end
    end
    ready <= #1 !stall;
  end
endmodule
`default_nettype wire

// ==== bench/sinc_decimator_reset_ctl_asserts.sv ====
// port assertions of the sinc decimator with reset sequencing
`timescale 1ns/1ns
`default_nettype none
`include "sinc_consts.svh"
module sinc_decimator_reset_ctl_asserts (
  // clock, reset, pins
  input wire logic                      CLK_IN,
  input wire logic                      RESETN_IN,
  input wire logic [`NCH-1:0]           MOD_BITS_IN,
  input wire logic                      RESYNC_RESETN_IN,
  // configuration
  input wire logic [2:0]                OVERSAMPLING_RATIO_IN,
  input wire logic                      OSR_LOAD_IN,
  input wire logic                      RESET_CMD_IN,
  input wire logic [`NCH-1:0]           CH_EN_IN,
  input wire logic [`NCH-1:0]           CH_CFG_CHG_IN,
  // status and stream
  input wire logic                      CONVERSION_READY_STROBE_N_OUT,
  input wire logic                      SERIAL_READY_OUT,
  input wire logic                      SINC3_ACTIVE_OUT,
  input wire logic [`NCH-1:0]           SETTLED_OUT,
  input wire logic [`NCH*`SAMPLE_W-1:0] DATA_OUT,
  input wire logic                      DATA_VALID_OUT,
  input wire logic                      DATA_READY_IN
);
  wire stb = CONVERSION_READY_STROBE_N_OUT;
  wire rdy = SERIAL_READY_OUT;
  wire s3 = SINC3_ACTIVE_OUT;
  logic        stb_d_r;
  logic [2:0]  code_r;
  logic [15:0] gap_r;
  logic        gap_ok_r;
  logic [2:0]  falls_r;
  wire fall = stb_d_r && !stb;
  wire restart = !rdy || !RESYNC_RESETN_IN || OSR_LOAD_IN || RESET_CMD_IN;
  // a gap is judged only between two falls with no restart between them
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      stb_d_r  <= 1'b0;
      code_r   <= `OSR_DEFAULT;
      gap_r    <= 16'h0000;
      gap_ok_r <= 1'b0;
      falls_r  <= 3'h0;
    end else begin
      stb_d_r  <= stb;
      gap_r    <= fall ? 16'h0001 : gap_r + 16'h0001;
      gap_ok_r <= restart ? 1'b0 : (fall ? 1'b1 : gap_ok_r);
      if (!rdy) begin
        code_r  <= `OSR_DEFAULT;
        falls_r <= 3'h0;
      end else begin
        if (OSR_LOAD_IN) begin
          code_r <= OVERSAMPLING_RATIO_IN;
        end
        if (fall && falls_r != 3'h4) begin
          falls_r <= falls_r + 3'h1;
        end
      end
    end
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  sequence strobe_low_s;
    !stb [*8];
  endsequence
  sequence reset_blip_s;
    (!rdy && !stb) ##1 (rdy && stb);
  endsequence
  ready_rise_a: assert property (
    $rose(rdy) |-> $rose(stb)) else $error("ready rose without strobe");
  strobe_in_reset_a: assert property (
    !rdy |-> !stb) else $error("strobe high before ready");
  strobe_pulse_a: assert property (
    $fell(stb) && rdy |-> strobe_low_s ##[1:2] stb)
    else $error("strobe low phase wrong length");
  cmd_reset_a: assert property (
    RESET_CMD_IN && rdy && RESYNC_RESETN_IN |=> reset_blip_s)
    else $error("reset command sequence wrong");
  path_gate_a: assert property (
    $rose(s3) |-> falls_r >= 3'h2 || (fall && falls_r == 3'h1))
    else $error("sinc3 path chosen too early");
  path_after_a: assert property (
    falls_r == 3'h4 && rdy |-> s3) else $error("sinc3 path not chosen");
  path_hold_a: assert property (
    $fell(s3) |-> !rdy || !$past(rdy)) else $error("sinc3 path left early");
  sample_gap_a: assert property (
    fall && gap_ok_r |-> gap_r == (16'h0100 << code_r))
    else $error("sample spacing wrong");
  data_hold_a: assert property (
    DATA_VALID_OUT && !DATA_READY_IN && rdy |=>
    (DATA_VALID_OUT && $stable(DATA_OUT)) || !rdy)
    else $error("head word changed before taken");
  settle_fall_a: assert property (
    (SETTLED_OUT & ~$past(SETTLED_OUT)) != 4'h0 |-> !stb)
    else $error("settled flag set away from strobe fall");
  settle_clear_a: assert property (
    CH_CFG_CHG_IN[1] && rdy |-> ##[1:2] !SETTLED_OUT[1])
    else $error("settling not restarted");
endmodule
`default_nettype wire

// ==== bench/sinc_decimator_reset_ctl_tb.sv ====
// self-checking bench of the sinc decimator and its reset sequencing
`timescale 1ns/1ns
`default_nettype none
module sinc_decimator_reset_ctl_tb;
  localparam int LIM = 70000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  mbits = 4'h1;
  logic        pin_n = 1'b1;
  logic [2:0]  code = 3'h0;
  logic        load = 1'b0;
  logic        cmd = 1'b0;
  logic [3:0]  en = 4'hF;
  logic [3:0]  chg = 4'h0;
  logic        stall = 1'b0;
  logic        stb_n;
  logic        rdy;
  logic        s3;
  logic [3:0]  settled;
  logic [63:0] data;
  logic        valid;
  logic        ready;
  logic [63:0] last;
  int          words;
  int          good;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          t;
  int          w0;
  always #5 clk = ~clk;
  sinc_decimator_reset_ctl #(.POR_SETTLE_CYC(20)) sinc_decimator_reset_ctl_inst (
    .CLK_IN(clk), .RESETN_IN(rst_n), .MOD_BITS_IN(mbits),
    .RESYNC_RESETN_IN(pin_n), .OVERSAMPLING_RATIO_IN(code),
    .OSR_LOAD_IN(load), .RESET_CMD_IN(cmd), .CH_EN_IN(en),
    .CH_CFG_CHG_IN(chg), .CONVERSION_READY_STROBE_N_OUT(stb_n),
    .SERIAL_READY_OUT(rdy), .SINC3_ACTIVE_OUT(s3), .SETTLED_OUT(settled),
    .DATA_OUT(data), .DATA_VALID_OUT(valid), .DATA_READY_IN(ready));
  sample_sink sample_sink_inst (
    .clk(clk), .valid(valid), .data(data), .ready(ready), .stall(stall),
    .settled(settled[0]), .words(words), .good_words(good), .last_word(last));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic step(inout int n);
    tick(1);
    n++;
  endtask
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      check("timeout", 1'b0, 1'b1);
      end_of_test();
    end
  endtask
  task automatic wait_fall(output int n);
    n = 0;
    while (stb_n !== 1'b1 && n < LIM) step(n);
    while (stb_n !== 1'b0 && n < LIM) step(n);
    give_up(n, LIM);
  endtask
  // host holds back until ready rises
  task automatic wait_ready(output int n);
    n = 0;
    while (rdy !== 1'b1 && n < 1000) step(n);
    give_up(n, 1000);
  endtask
  // kept clear of the strobe low phase so a restart cannot clip it
  task automatic set_ratio(input logic [2:0] c);
    tick(10);
    code = c;
    load = 1'b1;
    tick(1);
    load = 1'b0;
  endtask
  task automatic t_power_up();
    load = 1'b1;
    tick(1);
    load = 1'b0;
    wait_ready(t);
    check("por_wait", t >= 15 && t <= 22, 1'b1);
    check("strobe_up", stb_n, 1'b1);
    wait_fall(t);
    check("first_fall", t >= 2640 && t <= 2664, 1'b1);
    tick(3);
    check("fast_path", s3, 1'b0);
    wait_fall(t);
    check("gap_default", t + 3, 2048);
    wait_fall(t);
    tick(4);
    check("sinc3_path", s3, 1'b1);
    check("all_kept", words, 3);
    check("full_scale", last, 64'h8000800080007FFF);
    $display("t_power_up done");
  endtask
  task automatic t_ratios();
    for (int c = 0; c < 6; c++) begin
      set_ratio(c[2:0]);
      wait_fall(t);
      wait_fall(t);
      check("ratio_gap", t, 256 << c);
    end
    $display("t_ratios done");
  endtask
  task automatic t_settle();
    set_ratio(3'h0);
    en = 4'hB;
    repeat (6) wait_fall(t);
    tick(4);
    check("ch_off", last[47:32], 16'h0000);
    check("ch_on", last[15:0], 16'h7FFF);
    check("settled", settled & 4'hB, 4'hB);
    en = 4'hF;
    chg = 4'h2;
    tick(1);
    chg = 4'h0;
    tick(2);
    check("restart", settled[1], 1'b0);
    t = 0;
    while (settled[1] !== 1'b1 && t < 2000) step(t);
    give_up(t, 2000);
    check("settle_len", t + 3 >= 864 && t < 864 + 264, 1'b1);
    check("at_fall", stb_n, 1'b0);
    $display("t_settle done");
  endtask
  task automatic t_stall();
    stall = 1'b1;
    w0 = words;
    repeat (24) wait_fall(t);
    check("held", valid, 1'b1);
    stall = 1'b0;
    tick(60);
    check("buffered", words - w0 >= 17 && words - w0 <= 18, 1'b1);
    check("drained", valid, 1'b0);
    check("discarded", good < words, 1'b1);
    $display("t_stall done");
  endtask
  task automatic t_resets();
    wait_fall(t);
    tick(10);
    pin_n = 1'b0;
    tick(50);
    pin_n = 1'b1;
    tick(8);
    check("resync", {rdy, s3, settled}, 6'h30);
    wait_fall(t);
    tick(10);
    pin_n = 1'b0;
    tick(250);
    check("pin_reset", {rdy, stb_n, s3}, 3'h0);
    pin_n = 1'b1;
    wait_ready(t);
    check("pin_release", t <= 8, 1'b1);
    wait_fall(t);
    wait_fall(t);
    check("default_ratio", t, 2048);
    tick(10);
    cmd = 1'b1;
    tick(1);
    cmd = 1'b0;
    check("cmd_reset", {rdy, s3}, 2'h0);
    wait_ready(t);
    check("cmd_back", stb_n, 1'b1);
    $display("t_resets done");
  endtask
  initial begin
    tick(5);
    rst_n = 1'b1;
    t_power_up();
    t_ratios();
    t_settle();
    t_stall();
    t_resets();
    end_of_test();
  end
endmodule
bind sinc_decimator_reset_ctl sinc_decimator_reset_ctl_asserts
  sinc_decimator_reset_ctl_asserts_inst (
  .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .MOD_BITS_IN(MOD_BITS_IN),
  .RESYNC_RESETN_IN(RESYNC_RESETN_IN), .CH_EN_IN(CH_EN_IN),
  .OVERSAMPLING_RATIO_IN(OVERSAMPLING_RATIO_IN), .OSR_LOAD_IN(OSR_LOAD_IN),
  .RESET_CMD_IN(RESET_CMD_IN), .CH_CFG_CHG_IN(CH_CFG_CHG_IN),
  .CONVERSION_READY_STROBE_N_OUT(CONVERSION_READY_STROBE_N_OUT),
  .SERIAL_READY_OUT(SERIAL_READY_OUT), .SINC3_ACTIVE_OUT(SINC3_ACTIVE_OUT),
  .SETTLED_OUT(SETTLED_OUT), .DATA_OUT(DATA_OUT),
  .DATA_VALID_OUT(DATA_VALID_OUT), .DATA_READY_IN(DATA_READY_IN));
`default_nettype wire

// ==== src/sample_fifo.sv ====
// sample fifo with a registered head word
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // head register keeps the block output straight from a flop
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (cnt_r != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r      <= '0;
      rd_r      <= '0;
      cnt_r     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r     <= rd_r + 1'b1;
        out_data <= mem[rd_r];
      end
      if (pop) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== src/sinc_consts.svh ====
// constants of the decimation filter and its reset sequencing
`ifndef SINC_CONSTS_SVH
`define SINC_CONSTS_SVH
`define NCH            4
`define SAMPLE_W       16
`define ACC_W          32
`define ACC1_W         36
`define FAST_W         18
`define CONV_W         14
`define SET_W          16
`define WAIT_W         24
`define LOWC_W         12
`define FIFO_DEPTH     16
`define CLK_PERIOD_NS  10
`define POR_SETTLE_NS  250000
`define RESET_LOW_PULSE_MIN_NS 2000
`define MOD_DIV        2
`define START_WAIT_MOD 300
`define CONVERSION_READY_STROBE_LOW_MOD   4
`define OSR_DEFAULT    3'h3
`define OSR_K_BASE     7
`define SINC3_K_MAX    10
`define Q15_SHIFT      15
`define SETTLE_128     16'h01B0
`define SETTLE_256     16'h0330
`define SETTLE_512     16'h0630
`define SETTLE_1024    16'h0C30
`define SETTLE_2048    16'h1830
`define SETTLE_4096    16'h2830
`define SETTLE_8192    16'h4830
`define SETTLE_16384   16'h8830
`endif

// ==== src/sinc_decimator_reset_ctl.sv ====
// four-channel sinc decimator with reset and start-up sequencing
// Notes on behaviour
// R01: after any reset, sinc3 path output is used from the third sample on.
// R02: ratios 128 to 1024: sinc3 decimates by the full ratio, no sinc1.
// R03: ratios 2048 up: sinc3 decimates by 1024, sinc1 by the rest.
// R04: sinc3 is a cubed moving sum of length N, scaled by N cubed.
// R05: settling length per ratio is the fixed table in modulator periods.
// R06: settling restarts on enable, mux or gain change, or resync.
// R07: samples during settling are still delivered, neither dropped nor marked.
// R08: host tracks settling itself and drops early samples.
// R09: first strobe fall after settling expiry carries a settled sample.
// R10: power-on, pin or command reset restores defaults, then conversions run.
// R11: strobe rises after reset; serial traffic before it is ignored.
// R12: power-on waits the settle time, then raises the strobe at once.
// R13: pin low beyond the minimum pulse resets; held until pin goes high.
// R14: host waits access time or strobe rise after pin release.
// R15: first two samples after reset come from the fast sinc1 path.
// R16: a 3-bit ratio field picks eight ratios, 128 to 16384.
// R17: modulator clock is exactly half the main clock.
// R18: one filter per channel, all sharing one decimation timing.
`timescale 1ns/1ns
`default_nettype none
`include "sinc_consts.svh"
module sinc_decimator_reset_ctl
  import sinc_pkg::*;
#(
  parameter int POR_SETTLE_CYC =
    (`POR_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and power-on reset
  input  wire logic                      CLK_IN,
  input  wire logic                      RESETN_IN,
  // modulator bitstreams and resync/reset pin
  input  wire logic [`NCH-1:0]           MOD_BITS_IN,
  input  wire logic                      RESYNC_RESETN_IN,
  // configuration from the serial interface
  input  wire logic [2:0]                OVERSAMPLING_RATIO_IN,
  input  wire logic                      OSR_LOAD_IN,
  input  wire logic                      RESET_CMD_IN,
  input  wire logic [`NCH-1:0]           CH_EN_IN,
  input  wire logic [`NCH-1:0]           CH_CFG_CHG_IN,
  // status
  output logic                           CONVERSION_READY_STROBE_N_OUT,
  output logic                           SERIAL_READY_OUT,
  output logic                           SINC3_ACTIVE_OUT,
  output logic [`NCH-1:0]                SETTLED_OUT,
  // sample stream
  output logic [`NCH*`SAMPLE_W-1:0]      DATA_OUT,
  output logic                           DATA_VALID_OUT,
  input  wire logic                      DATA_READY_IN
);
  localparam int RST_LOW_CYC =
    (`RESET_LOW_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int START_WAIT_CYC = `START_WAIT_MOD * `MOD_DIV;
  localparam int CONVERSION_READY_STROBE_LOW_CYC = `CONVERSION_READY_STROBE_LOW_MOD * `MOD_DIV;
  localparam logic [`WAIT_W-1:0] POR_LAST = `WAIT_W'(POR_SETTLE_CYC - 1);
  localparam logic [`WAIT_W-1:0] START_LAST = `WAIT_W'(START_WAIT_CYC - 1);
  localparam logic [`LOWC_W-1:0] LOW_LIMIT = `LOWC_W'(RST_LOW_CYC);

  function automatic ctl_t reset_image();
    ctl_t r;
    r = '0;
    r.phase = ST_POR_WAIT;
    r.oversampling_ratio = `OSR_DEFAULT;
    r.rst_s1 = 1'b1;
    r.rst_s2 = 1'b1;
    r.rst_s3 = 1'b1;
    r.rst_stable = 1'b1;
    return r;
  endfunction

  localparam ctl_t CTL_RESET = reset_image();

  // log2 of the selected ratio
  function automatic int osr_k(input logic [2:0] oversampling_ratio);
    return `OSR_K_BASE + int'(oversampling_ratio);
  endfunction

  function automatic logic [`CONV_W-1:0] conv_last(input logic [2:0] oversampling_ratio);
    return `CONV_W'((1 << osr_k(oversampling_ratio)) - 1);
  endfunction

  // sinc3 never decimates beyond 1024
  function automatic logic [`CONV_W-1:0] dec_mask(input logic [2:0] oversampling_ratio);
    int k3;
    k3 = (osr_k(oversampling_ratio) > `SINC3_K_MAX) ? `SINC3_K_MAX : osr_k(oversampling_ratio);
    return `CONV_W'((1 << k3) - 1);
  endfunction

  function automatic logic [`SET_W-1:0] settle_len(input logic [2:0] oversampling_ratio);
    case (oversampling_ratio)
      3'h0: return `SETTLE_128;
      3'h1: return `SETTLE_256;
      3'h2: return `SETTLE_512;
      3'h3: return `SETTLE_1024;
      3'h4: return `SETTLE_2048;
      3'h5: return `SETTLE_4096;
      3'h6: return `SETTLE_8192;
      default: return `SETTLE_16384;
    endcase
  endfunction

  // full scale of each path maps to the 16-bit signed range
  function automatic logic [`SAMPLE_W-1:0] sat16(
    input logic signed [`ACC1_W-1:0] v
  );
    if (v > 36'sh0_0000_7FFF) begin
      return 16'h7FFF;
    end else if (v < -36'sh0_0000_8000) begin
      return 16'h8000;
    end else begin
      return v[`SAMPLE_W-1:0];
    end
  endfunction

  ctl_t s;
  ctl_t n;
  logic                      tick;
  logic                      dec;
  logic                      conv;
  logic                      pin_rst;
  logic                      cmd_rst;
  logic                      release_rst;
  logic                      resync;
  logic                      rst_agree;
  logic [`NCH-1:0]           agree;
  logic [`NCH-1:0]           restart;
  logic                      fifo_ready;
  logic [`ACC_W-1:0]         x;
  logic [`ACC_W-1:0]         c1;
  logic [`ACC_W-1:0]         c2;
  logic [`ACC_W-1:0]         c3;
  logic signed [`ACC1_W-1:0] y3;
  logic signed [`ACC1_W-1:0] tot1;
  logic signed [`ACC1_W-1:0] totf;
  logic [`SAMPLE_W-1:0]      s3val;
  logic [`SAMPLE_W-1:0]      fval;
  logic [`NCH*`SAMPLE_W-1:0] samples;
  int                        k;

  always_comb begin
    n = s;
    x = '0;
    c1 = '0;
    c2 = '0;
    c3 = '0;
    y3 = '0;
    tot1 = '0;
    totf = '0;
    s3val = '0;
    fval = '0;
    samples = '0;
    restart = '0;
    release_rst = 1'b0;
    k = osr_k(s.oversampling_ratio);

    // pin inputs: a change counts once the second and third stage agree
    n.mbit_s1 = MOD_BITS_IN;
    n.mbit_s2 = s.mbit_s1;
    n.mbit_s3 = s.mbit_s2;
    agree = ~(s.mbit_s2 ^ s.mbit_s3);
    n.mbit = (s.mbit & ~agree) | (s.mbit_s3 & agree);
    n.rst_s1 = RESYNC_RESETN_IN;
    n.rst_s2 = s.rst_s1;
    n.rst_s3 = s.rst_s2;
    rst_agree = (s.rst_s2 == s.rst_s3);
    if (rst_agree) begin
      n.rst_stable = s.rst_s3;
    end
    if (!s.rst_stable) begin
      if (s.low_cnt != LOW_LIMIT) begin
        n.low_cnt = s.low_cnt + 1'b1;
      end
    end else begin
      n.low_cnt = '0;
    end
    pin_rst = !s.rst_stable && (s.low_cnt == LOW_LIMIT); // see R13
    // a short low pulse only realigns the filters
    resync = !s.rst_stable && n.rst_stable && !pin_rst;
    // commands before the strobe rise are dropped
    cmd_rst = RESET_CMD_IN && s.ready; // see R11

    // modulator rate is half the main clock
    n.mod_ph = ~s.mod_ph; // see R17
    tick = s.mod_ph && (s.phase == ST_RUN);
    dec = tick && ((s.conv_cnt & dec_mask(s.oversampling_ratio)) == dec_mask(s.oversampling_ratio));
    conv = tick && (s.conv_cnt == conv_last(s.oversampling_ratio)); // see R16
    if (tick) begin
      n.conv_cnt = conv ? '0 : s.conv_cnt + 1'b1; // see R18
    end

    case (s.phase)
      ST_POR_WAIT: begin
        if (s.wait_cnt == POR_LAST) begin
          release_rst = 1'b1; // see R12
        end else begin
          n.wait_cnt = s.wait_cnt + 1'b1;
        end
      end
      ST_IN_RESET: begin
        release_rst = s.rst_stable; // see R13
      end
      ST_START_WAIT: begin
        if (s.wait_cnt == START_LAST) begin
          n.phase = ST_RUN;
          restart = '1;
        end else begin
          n.wait_cnt = s.wait_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        if (s.pend_v && fifo_ready) begin
          n.pend_v = 1'b0;
        end
        if (!s.conversion_ready_strobe_n) begin
          if (s.conversion_ready_strobe_cnt == '0) begin
            n.conversion_ready_strobe_n = 1'b1;
          end else begin
            n.conversion_ready_strobe_cnt = s.conversion_ready_strobe_cnt - 1'b1;
          end
        end
      end
      default: begin
        n.phase = ST_POR_WAIT;
      end
    endcase
    if (release_rst) begin
      n.phase = ST_START_WAIT;
      n.wait_cnt = '0;
      n.conversion_ready_strobe_n = 1'b1; // see R11
      n.ready = 1'b1;
    end

    if (OSR_LOAD_IN && s.ready) begin
      n.oversampling_ratio = OVERSAMPLING_RATIO_IN;
      restart = '1;
    end
    n.ch_en_d = CH_EN_IN;
    for (int c = 0; c < `NCH; c++) begin
      if (resync || CH_CFG_CHG_IN[c] || (CH_EN_IN[c] && !s.ch_en_d[c])) begin
        restart[c] = 1'b1; // see R06
      end
    end

    for (int c = 0; c < `NCH; c++) begin
      // bit 1 weighs +1, bit 0 weighs -1
      x = s.mbit[c] ? 32'h0000_0001 : 32'hFFFF_FFFF;
      // integrators wrap; the comb difference stays exact
      if (tick) begin
        n.i1[c] = s.i1[c] + x; // see R04
        n.i2[c] = s.i2[c] + n.i1[c];
        n.i3[c] = s.i3[c] + n.i2[c];
        n.fast[c] = s.fast[c] + x[`FAST_W-1:0];
      end
      c1 = n.i3[c] - s.d1[c];
      c2 = c1 - s.d2[c];
      c3 = c2 - s.d3[c];
      y3 = {{(`ACC1_W - `ACC_W){c3[`ACC_W-1]}}, c3};
      tot1 = signed'(s.acc1[c]) + y3;
      totf = {{(`ACC1_W - `FAST_W){s.fast[c][`FAST_W-1]}}, s.fast[c]};
      totf = totf + {{(`ACC1_W - 1){~s.mbit[c]}}, 1'b1};
      if (dec) begin
        n.d1[c] = n.i3[c];
        n.d2[c] = c1;
        n.d3[c] = c2;
        n.acc1[c] = conv ? '0 : tot1; // see R03
      end
      if (k <= `SINC3_K_MAX) begin
        s3val = sat16(y3 >>> (3 * k - `Q15_SHIFT)); // see R02
      end else begin
        s3val = sat16(tot1 >>> (k + 5)); // see R03
      end
      fval = sat16(totf <<< (`Q15_SHIFT - k));
      if (conv) begin
        n.fast[c] = '0;
      end
      if (CH_EN_IN[c]) begin
        samples[c*`SAMPLE_W +: `SAMPLE_W] =
          s.path_sinc3 ? s3val : fval; // see R15
      end
      if (tick && s.settle_cnt[c] != '0) begin
        n.settle_cnt[c] = s.settle_cnt[c] - 1'b1;
      end
      // settled shows with the strobe fall that follows expiry
      if (conv && s.settle_cnt[c] == '0 && CH_EN_IN[c]) begin
        n.settled[c] = 1'b1; // see R09
      end
      if (restart[c]) begin
        n.settle_cnt[c] = settle_len(n.oversampling_ratio); // see R05
        n.settled[c] = 1'b0;
      end
      if (!CH_EN_IN[c] || resync || (OSR_LOAD_IN && s.ready)) begin
        n.i1[c] = '0;
        n.i2[c] = '0;
        n.i3[c] = '0;
        n.d1[c] = '0;
        n.d2[c] = '0;
        n.d3[c] = '0;
        n.acc1[c] = '0;
        n.fast[c] = '0;
        n.settled[c] = 1'b0;
      end
    end
    if (resync || (OSR_LOAD_IN && s.ready)) begin
      n.conv_cnt = '0;
    end

    // unsettled samples still go out unmarked; last one wins if stalled
    if (conv) begin
      n.pend = samples; // see R07
      n.pend_v = 1'b1;
      n.conversion_ready_strobe_n = 1'b0;
      n.conversion_ready_strobe_cnt = 4'(CONVERSION_READY_STROBE_LOW_CYC - 1);
      if (s.conv_seen != 2'h2) begin
        n.conv_seen = s.conv_seen + 1'b1;
      end
      n.path_sinc3 = (s.conv_seen != 2'h0); // see R01
    end

    // every reset wipes configuration and filters back to defaults
    if (pin_rst || cmd_rst) begin
      n = CTL_RESET; // see R10
      n.phase = ST_IN_RESET;
      n.mod_ph = ~s.mod_ph;
      n.mbit_s1 = MOD_BITS_IN;
      n.mbit_s2 = s.mbit_s1;
      n.mbit_s3 = s.mbit_s2;
      n.mbit = (s.mbit & ~agree) | (s.mbit_s3 & agree);
      n.rst_s1 = RESYNC_RESETN_IN;
      n.rst_s2 = s.rst_s1;
      n.rst_s3 = s.rst_s2;
      n.rst_stable = rst_agree ? s.rst_s3 : s.rst_stable;
      n.low_cnt = pin_rst ? s.low_cnt : '0;
      n.ch_en_d = CH_EN_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s <= CTL_RESET;
    end else begin
      s <= n;
    end
  end

  sample_fifo #(
    .WIDTH(`NCH*`SAMPLE_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_IN),
    .rst_n     (RESETN_IN),
    .in_valid  (s.pend_v),
    .in_ready  (fifo_ready),
    .in_data   (s.pend),
    .out_valid (DATA_VALID_OUT),
    .out_ready (DATA_READY_IN),
    .out_data  (DATA_OUT)
  );

  assign CONVERSION_READY_STROBE_N_OUT = s.conversion_ready_strobe_n;
  assign SERIAL_READY_OUT = s.ready;
  assign SINC3_ACTIVE_OUT = s.path_sinc3;
  assign SETTLED_OUT = s.settled;
endmodule
`default_nettype wire

// ==== src/sinc_pkg.sv ====
// types of the decimation filter and its reset sequencing
`include "sinc_consts.svh"
package sinc_pkg;
  typedef enum logic [1:0] {
    ST_POR_WAIT, ST_IN_RESET, ST_START_WAIT, ST_RUN
  } phase_t;
  typedef logic [`NCH-1:0][`ACC_W-1:0] acc_arr_t;
  typedef struct packed {
    phase_t                         phase;
    logic [`WAIT_W-1:0]             wait_cnt;
    logic                           mod_ph;
    logic [`NCH-1:0]                mbit_s1;
    logic [`NCH-1:0]                mbit_s2;
    logic [`NCH-1:0]                mbit_s3;
    logic [`NCH-1:0]                mbit;
    logic                           rst_s1;
    logic                           rst_s2;
    logic                           rst_s3;
    logic                           rst_stable;
    logic [`LOWC_W-1:0]             low_cnt;
    logic [2:0]                     oversampling_ratio;
    logic [`CONV_W-1:0]             conv_cnt;
    logic [1:0]                     conv_seen;
    logic                           path_sinc3;
    acc_arr_t                       i1;
    acc_arr_t                       i2;
    acc_arr_t                       i3;
    acc_arr_t                       d1;
    acc_arr_t                       d2;
    acc_arr_t                       d3;
    logic [`NCH-1:0][`ACC1_W-1:0]   acc1;
    logic [`NCH-1:0][`FAST_W-1:0]   fast;
    logic [`NCH*`SAMPLE_W-1:0]      pend;
    logic                           pend_v;
    logic                           conversion_ready_strobe_n;
    logic [3:0]                     conversion_ready_strobe_cnt;
    logic                           ready;
    logic [`NCH-1:0][`SET_W-1:0]    settle_cnt;
    logic [`NCH-1:0]                settled;
    logic [`NCH-1:0]                ch_en_d;
  } ctl_t;
endpackage
